// >>> rtl/ule_crc5_chk.sv
/*
 * ule_crc5_chk: checks the 5-bit CRC of a link control word.
 * assumes crc covers the low 11 bits, msb first, result inverted.
 */
`timescale 1ns/100ps
module ule_crc5_chk (
    // word under test
    input wire ule_pkg::ule_lcw_s word_i,
    // result
    output logic ok_o
);
    import ule_pkg::*;

    always_comb begin
        logic [4:0] c;
        logic [10:0] d;
        logic fb;
        c = CRC5_INIT;
        d = {word_i.ctype, word_i.rsvd, word_i.arg};
        fb = 1'b0;
        for (int i = 10; i >= 0; i--) begin
            fb = c[4] ^ d[i];
            c = {c[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
        end
        ok_o = (~c == word_i.crc); // R7
    end
endmodule // ule_crc5_chk

// >>> rtl/ule_frame_det.sv
/*
 * ule_frame_det: spots a four-symbol framing ordered set, one symbol
 * may be corrupt. assumes sym_i is the current symbol; hit_o is combinational.
 */
`timescale 1ns/100ps
module ule_frame_det #(
    parameter logic [7:0] K_CODE = ule_pkg::K_SHP
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // symbol stream
    input wire ule_pkg::ule_sym_s sym_i,
    // detection
    output logic hit_o
);
    import ule_pkg::*;

    ule_sym_s win_reg [FRAME_LEN-1];
    logic [FRAME_LEN-1:0] good;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < FRAME_LEN-1; i++) win_reg[i] <= '0;
        end else if (sym_i.valid) begin
            for (int i = 0; i < FRAME_LEN-2; i++) win_reg[i] <= win_reg[i+1];
            win_reg[FRAME_LEN-2] <= sym_i;
        end
    end

    // last position must be EPF, the others the framing K
    for (genvar g = 0; g < FRAME_LEN; g++) begin : g_pos
        if (g == FRAME_LEN-1) begin : g_last
            assign good[g] = sym_i.k && (sym_i.d == K_EPF);
        end else begin : g_head
            assign good[g] = win_reg[g].valid && win_reg[g].k && (win_reg[g].d == K_CODE);
        end
    end

    assign hit_o = sym_i.valid && ($countones(good) >= FRAME_MIN_GOOD); // R1 R2 R13
endmodule // ule_frame_det

// >>> rtl/ule_link_err.sv
/*
 * ule_link_err: link-layer error detection and recovery decision.
 * assumes one decoded symbol per clock and that neighbouring link
 * logic runs the link timers and reports their expiry as pulses.
 */
// Contract
// (R1) header start seen when three of four symbols are good framing K
// (R2) framing order is three K then EPF, one corrupt position allowed
// (R3) pending header timer expiry sends the port to Recovery
// (R4) rx sequence mismatch of a receiver sends it to Recovery first
// (R5) each error Recovery raises the link error count by one
// (R6) header error on CRC failure or K-symbol inside header or word
// (R7) control word checked with CRC-5, header with CRC-16
// (R8) header error answers with LBAD, count unchanged
// (R9) three consecutive header failures force Recovery and count one
// (R10) rx sequence number cleared on every U0 entry
// (R11) good header with wrong sequence number forces Recovery
// (R12) link command is LCSTART, command word, identical repeat
// (R13) link command seen on three of four SLC SLC SLC EPF symbols
// (R14) accept when both words equal, defined and CRC-5 clean
// (R15) accept differing words when exactly one is defined and clean
// (R16) other detected link commands are dropped silently
// (R17) LGOOD_n out of order or pending timer expiry forces Recovery
// (R18) LCRD_x out of order or credit timer expiry forces Recovery
// (R19) PM command timer expiry before LAU or LXU forces Recovery
// (R20) downstream port with missing LUP enters Recovery
// (R21) missing LPMA never forces Recovery
// (R22) errors without Recovery leave the count alone
// (R23) only a downstream port keeps the count
// (R24) count clears on resets and on Polling.Idle entry
`timescale 1ns/100ps
module ule_link_err (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // received symbols
    input wire ule_pkg::ule_sym_s sym_i,
    // link state and role
    input wire logic u0_entry_i,
    input wire logic is_dsp_i,
    input wire logic hot_reset_i,
    input wire logic warm_reset_i,
    input wire logic polling_idle_i,
    // timers and events of neighbouring link logic
    input wire logic pending_hp_expired_i,
    input wire logic credit_hp_expired_i,
    input wire logic pm_lc_expired_i,
    input wire logic lgo_sent_i,
    input wire logic lup_missing_i,
    // header results
    output logic lbad_o,
    output logic hp_good_o,
    output logic [2:0] rx_hsn_o,
    // link command results
    output logic lcmd_valid_o,
    output ule_pkg::ule_lcw_s lcmd_o,
    // recovery and count
    output logic recovery_o,
    output ule_pkg::ule_cause_s cause_o,
    output logic [ule_pkg::CNT_W-1:0] link_err_cnt_o
);
    import ule_pkg::*;

    ule_state_e state_reg;
    logic [3:0] idx_reg;
    logic [15:0] crc_reg;
    logic [7:0] hist_reg [3];
    logic k_seen_reg, k_hi_reg;
    logic [2:0] rx_hsn_reg;
    logic [1:0] fail_cnt_reg;
    logic armed_reg, pm_wait_reg;
    logic lg_have_reg, lc_have_reg;
    logic [2:0] lg_last_reg;
    logic [1:0] lc_last_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic hp_hit, lc_hit, crc5_a_ok, crc5_b_ok;
    ule_lcw_s word_a, word_b, acc_word;
    logic hp_eval, lc_eval, hp_bad, hsn_bad, ok_a, ok_b, accept;
    logic fire, cnt_clr;
    ule_cause_s cause_next;

    function automatic logic [15:0] crc16_byte(input logic [15:0] c_in, input logic [7:0] b);
        logic [15:0] c;
        logic fb;
        c = c_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = c[15] ^ b[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
        end
        return c;
    endfunction

    function automatic logic lc_defined(input ule_lcw_s w);
        return (w.ctype <= LC_TYPE_MAX) && (w.rsvd == 4'h0);
    endfunction

    ule_frame_det #(.K_CODE(K_SHP)) u_hp_frame (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sym_i(sym_i),
        .hit_o(hp_hit)
    );
    ule_frame_det #(.K_CODE(K_SLC)) u_lc_frame (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sym_i(sym_i),
        .hit_o(lc_hit)
    );

    // both packet kinds end with a two-symbol word after a two-symbol field
    assign word_a = {hist_reg[1], hist_reg[2]};
    assign word_b = {sym_i.d, hist_reg[0]};

    ule_crc5_chk u_crc5_a (
        .word_i(word_a),
        .ok_o(crc5_a_ok)
    );
    ule_crc5_chk u_crc5_b (
        .word_i(word_b),
        .ok_o(crc5_b_ok)
    );

    assign hp_eval = sym_i.valid && (state_reg == ST_HDR) && (idx_reg == HP_LAST);
    assign lc_eval = sym_i.valid && (state_reg == ST_LCMD) && (idx_reg == LC_LAST);
    // word_a here carries the received crc-16
    assign hp_bad = k_seen_reg || sym_i.k || (~crc_reg != 16'(word_a)) || !crc5_b_ok; // R6 R7
    assign hsn_bad = !hp_bad && (word_b.arg != rx_hsn_reg); // R11
    assign ok_a = !k_seen_reg && crc5_a_ok && lc_defined(word_a);
    assign ok_b = !k_hi_reg && !sym_i.k && crc5_b_ok && lc_defined(word_b);
    assign accept = (word_a == word_b) ? (ok_a && ok_b) : (ok_a ^ ok_b); // R14 R15 R16
    assign acc_word = ok_a ? word_a : word_b;

    always_comb begin
        cause_next = '0;
        cause_next.pending_hp = pending_hp_expired_i; // R3 R17
        cause_next.credit_hp = credit_hp_expired_i; // R18
        cause_next.pm_lc = pm_lc_expired_i && pm_wait_reg; // R19
        cause_next.lup = lup_missing_i && is_dsp_i; // R20
        cause_next.hsn = hp_eval && hsn_bad; // R4 R11
        cause_next.hp_fail = hp_eval && hp_bad && (fail_cnt_reg == HP_FAIL_LIMIT - 2'h1); // R9
        cause_next.lgood_seq = lc_eval && accept && (acc_word.ctype == LC_LGOOD) && lg_have_reg
            && (acc_word.arg != lg_last_reg + 3'h1); // R17
        cause_next.lcrd_seq = lc_eval && accept && (acc_word.ctype == LC_LCRD) && lc_have_reg
            && (acc_word.arg[1:0] != lc_last_reg + 2'h1); // R18
    end

    // one Recovery per stay in U0; LPMA loss has no cause at all (R21)
    assign fire = armed_reg && (cause_next != '0); // R21
    assign cnt_clr = hot_reset_i || warm_reset_i || polling_idle_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            idx_reg <= 4'h0;
        end else if (u0_entry_i) begin
            state_reg <= ST_IDLE;
            idx_reg <= 4'h0;
        end else if (sym_i.valid) begin
            case (state_reg)
                ST_IDLE: begin
                    idx_reg <= 4'h0;
                    if (hp_hit) begin
                        state_reg <= ST_HDR; // R1 R2
                    end else if (lc_hit) begin
                        state_reg <= ST_LCMD; // R12 R13
                    end
                end
                ST_HDR, ST_LCMD: begin
                    idx_reg <= idx_reg + 4'h1;
                    if (hp_eval || lc_eval) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // body capture: running crc-16 and the last three bytes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            crc_reg <= CRC16_INIT;
            k_seen_reg <= 1'b0;
            k_hi_reg <= 1'b0;
            for (int i = 0; i < 3; i++) hist_reg[i] <= 8'h00;
        end else if (sym_i.valid) begin
            if (state_reg == ST_IDLE) begin
                crc_reg <= CRC16_INIT;
                k_seen_reg <= 1'b0;
                k_hi_reg <= 1'b0;
            end else begin
                hist_reg[2] <= hist_reg[1];
                hist_reg[1] <= hist_reg[0];
                hist_reg[0] <= sym_i.d;
                if (state_reg == ST_HDR && idx_reg < HDR_BYTES) begin
                    crc_reg <= crc16_byte(crc_reg, sym_i.d); // R7
                end
                if (sym_i.k && (state_reg == ST_HDR || idx_reg < LC_WORD_LEN)) begin
                    k_seen_reg <= 1'b1; // R6
                end
                if (sym_i.k && state_reg == ST_LCMD && idx_reg >= LC_WORD_LEN) begin
                    k_hi_reg <= 1'b1;
                end
            end
        end
    end

    // header sequence and failure tracking
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rx_hsn_reg <= 3'h0;
            fail_cnt_reg <= 2'h0;
        end else if (u0_entry_i) begin
            rx_hsn_reg <= 3'h0; // R10
            fail_cnt_reg <= 2'h0;
        end else if (hp_eval) begin
            if (hp_bad) begin
                fail_cnt_reg <= cause_next.hp_fail ? 2'h0 : fail_cnt_reg + 2'h1; // R9
            end else if (!hsn_bad) begin
                rx_hsn_reg <= rx_hsn_reg + 3'h1;
                fail_cnt_reg <= 2'h0;
            end
        end
    end

    // link command ordering and power-management wait
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || u0_entry_i) begin
            lg_have_reg <= 1'b0;
            lc_have_reg <= 1'b0;
            lg_last_reg <= 3'h0;
            lc_last_reg <= 2'h0;
            pm_wait_reg <= 1'b0;
        end else begin
            if (lc_eval && accept && acc_word.ctype == LC_LGOOD) begin
                lg_have_reg <= 1'b1;
                lg_last_reg <= acc_word.arg;
            end
            if (lc_eval && accept && acc_word.ctype == LC_LCRD) begin
                lc_have_reg <= 1'b1;
                lc_last_reg <= acc_word.arg[1:0];
            end
            // a fresh request wins over a same-cycle answer
            if (lgo_sent_i) begin
                pm_wait_reg <= 1'b1;
            end else if (fire || (lc_eval && accept && (acc_word.ctype == LC_LAU || acc_word.ctype == LC_LXU))) begin
                pm_wait_reg <= 1'b0; // R19
            end
        end
    end

    // recovery decision and error count
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            armed_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            if (u0_entry_i) begin
                armed_reg <= 1'b1;
            end else if (fire) begin
                armed_reg <= 1'b0;
            end
            if (cnt_clr) begin
                cnt_reg <= '0; // R24
            end else if (fire && is_dsp_i) begin
                cnt_reg <= cnt_reg + 1'b1; // R5 R22 R23
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lbad_o <= 1'b0;
            hp_good_o <= 1'b0;
            lcmd_valid_o <= 1'b0;
            lcmd_o <= '0;
            recovery_o <= 1'b0;
            cause_o <= '0;
        end else begin
            lbad_o <= hp_eval && hp_bad; // R8
            hp_good_o <= hp_eval && !hp_bad && !hsn_bad;
            lcmd_valid_o <= lc_eval && accept; // R14 R15 R16
            if (lc_eval && accept) begin
                lcmd_o <= acc_word;
            end
            recovery_o <= fire;
            cause_o <= fire ? cause_next : '0;
        end
    end

    assign rx_hsn_o = rx_hsn_reg;
    assign link_err_cnt_o = cnt_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_lbad_no_cnt;
        hp_eval && hp_bad && !cause_next.hp_fail && !fire && !cnt_clr |=> $stable(link_err_cnt_o) && lbad_o;
    endproperty
    a_lbad_no_cnt: assert property (p_lbad_no_cnt) else $error("lbad changed the error count"); // R8
    property p_cnt_inc;
        fire && is_dsp_i && !cnt_clr |=> recovery_o && link_err_cnt_o == $past(link_err_cnt_o) + 1'b1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("recovery did not count once"); // R5
    property p_third_fail;
        armed_reg && hp_eval && hp_bad && fail_cnt_reg == 2'h2 |=> recovery_o && cause_o.hp_fail;
    endproperty
    a_third_fail: assert property (p_third_fail) else $error("third header failure missed"); // R9
    property p_hsn_init;
        u0_entry_i |=> rx_hsn_o == 3'h0;
    endproperty
    a_hsn_init: assert property (p_hsn_init) else $error("rx sequence not cleared"); // R10
    property p_pending;
        armed_reg && pending_hp_expired_i |=> recovery_o ##1 !recovery_o;
    endproperty
    a_pending: assert property (p_pending) else $error("pending timer did not recover"); // R3
    property p_credit;
        armed_reg && credit_hp_expired_i |=> recovery_o && cause_o.credit_hp;
    endproperty
    a_credit: assert property (p_credit) else $error("credit timer did not recover"); // R18
    property p_pm;
        armed_reg && pm_lc_expired_i && pm_wait_reg |=> recovery_o && cause_o.pm_lc;
    endproperty
    a_pm: assert property (p_pm) else $error("pm timer did not recover"); // R19
    property p_cnt_clear;
        cnt_clr |=> link_err_cnt_o == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared"); // R24
    property p_usp_cnt;
        !is_dsp_i && !cnt_clr |=> $stable(link_err_cnt_o);
    endproperty
    a_usp_cnt: assert property (p_usp_cnt) else $error("upstream port counted"); // R23
    property p_lc_drop;
        lc_eval && !accept |=> !lcmd_valid_o && $stable(lcmd_o);
    endproperty
    a_lc_drop: assert property (p_lc_drop) else $error("invalid command accepted"); // R16
    property p_hpstart;
        state_reg == ST_IDLE && hp_hit && !u0_entry_i |=> state_reg == ST_HDR ##15 (!sym_i.valid || state_reg != ST_IDLE);
    endproperty
    a_hpstart: assert property (p_hpstart) else $error("header start not followed"); // R1

    c_lbad: cover property (lbad_o);
    c_lcmd: cover property (lcmd_valid_o);
    c_hsn_rec: cover property (recovery_o && cause_o.hsn);
    c_cnt_two: cover property (link_err_cnt_o == 16'h0002);
endmodule // ule_link_err

// >>> rtl/ule_pkg.sv
/*
 * ule_pkg: shared constants and types of the link error detector.
 * assumes one decoded symbol per clock (data byte plus K flag).
 */
package ule_pkg;
    // framing symbol codes (byte value of the K-symbol)
    localparam logic [7:0] K_SHP = 8'hfb;
    localparam logic [7:0] K_SLC = 8'h5c;
    localparam logic [7:0] K_EPF = 8'hf7;
    localparam int FRAME_LEN = 4;
    localparam int FRAME_MIN_GOOD = 3;
    // header packet: 12 header bytes, crc-16 (2), link control word (2)
    localparam logic [3:0] HDR_BYTES = 4'hc;
    localparam logic [3:0] HP_LAST = 4'hf;
    // link command: word then repeat, two symbols each
    localparam logic [3:0] LC_WORD_LEN = 4'h2;
    localparam logic [3:0] LC_LAST = 4'h3;
    localparam logic [15:0] CRC16_POLY = 16'h100b;
    localparam logic [15:0] CRC16_INIT = 16'hffff;
    localparam logic [4:0] CRC5_POLY = 5'h05;
    localparam logic [4:0] CRC5_INIT = 5'h1f;
    localparam logic [1:0] HP_FAIL_LIMIT = 2'h3;
    localparam int CNT_W = 16;
    // link command types
    localparam logic [3:0] LC_LGOOD = 4'h0;
    localparam logic [3:0] LC_LCRD = 4'h1;
    localparam logic [3:0] LC_LRTY = 4'h2;
    localparam logic [3:0] LC_LBAD = 4'h3;
    localparam logic [3:0] LC_LGO_U1 = 4'h4;
    localparam logic [3:0] LC_LGO_U2 = 4'h5;
    localparam logic [3:0] LC_LGO_U3 = 4'h6;
    localparam logic [3:0] LC_LAU = 4'h7;
    localparam logic [3:0] LC_LXU = 4'h8;
    localparam logic [3:0] LC_LPMA = 4'h9;
    localparam logic [3:0] LC_LUP = 4'ha;
    localparam logic [3:0] LC_TYPE_MAX = LC_LUP;

    typedef struct packed {
        logic       valid;
        logic       k;
        logic [7:0] d;
    } ule_sym_s;

    // link control word; arg holds HSN, LGOOD_n or LCRD_x letter
    typedef struct packed {
        logic [4:0] crc;
        logic [3:0] ctype;
        logic [3:0] rsvd;
        logic [2:0] arg;
    } ule_lcw_s;

    typedef struct packed {
        logic pending_hp;
        logic credit_hp;
        logic pm_lc;
        logic lup;
        logic hsn;
        logic hp_fail;
        logic lgood_seq;
        logic lcrd_seq;
    } ule_cause_s;

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_LCMD} ule_state_e;
endpackage

// >>> test/ule_link_partner.sv
/*
 * ule_link_partner: far-end link layer sending framed header packets and
 * link commands. assumes its tasks are entered 1 ns after a rising edge.
 */
`timescale 1ns/100ps
module ule_link_partner (
    // clock
    input wire logic clk_sys_i,
    // symbols towards the port
    output ule_pkg::ule_sym_s sym_o
);
    import ule_pkg::*;

    initial sym_o = '0;

    task automatic put(input logic k, input logic [7:0] d);
        sym_o = {1'b1, k, d};
        @(posedge clk_sys_i);
        #1;
    endtask

    // released line shows the inverse of the last byte, never a stale copy
    task automatic idle();
        sym_o = {1'b0, 1'b0, ~sym_o.d};
    endtask

    // a corrupted position carries a data symbol instead of the K-symbol
    task automatic frame(input logic [7:0] code, input logic [3:0] bad);
        for (int i = 0; i < 4; i++) begin
            if (bad[i]) put(1'b0, 8'h3c);
            else put(1'b1, (i == 3) ? K_EPF : code);
        end
    endtask

    function automatic ule_lcw_s mk_lcw(input logic [3:0] t, input logic [3:0] r, input logic [2:0] a);
        logic [4:0] c;
        logic [10:0] w;
        w = {t, r, a};
        c = CRC5_INIT;
        for (int i = 10; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ w[i]) ? CRC5_POLY : 5'h00);
        return {~c, t, r, a};
    endfunction

    // kind 1 spoils the header crc, 2 the word crc, 3 puts a K in the header
    task automatic send_hp(input logic [2:0] hsn, input int kind, input logic [3:0] bad);
        logic [15:0] c;
        logic [7:0] b;
        ule_lcw_s w;
        c = CRC16_INIT;
        w = mk_lcw(LC_LGOOD, 4'h0, hsn);
        if (kind == 2) w.crc = ~w.crc;
        frame(K_SHP, bad);
        for (int i = 0; i < 12; i++) begin
            b = 8'h21 + 8'(i * 7);
            for (int j = 0; j < 8; j++) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? CRC16_POLY : 16'h0000);
            put(kind == 3 && i == 5, b);
        end
        c = ~c ^ ((kind == 1) ? 16'h0001 : 16'h0000);
        put(1'b0, c[7:0]);
        put(1'b0, c[15:8]);
        put(1'b0, w[7:0]);
        put(1'b0, w[15:8]);
        idle();
    endtask

    task automatic send_lc(input ule_lcw_s a, input ule_lcw_s b, input logic [3:0] bad);
        frame(K_SLC, bad);
        put(1'b0, a[7:0]);
        put(1'b0, a[15:8]);
        put(1'b0, b[7:0]);
        put(1'b0, b[15:8]);
        idle();
    endtask
endmodule // ule_link_partner

// >>> test/usb3_link_error_detect_bench.sv
/*
 * usb3_link_error_detect_bench: self-checking bench of ule_link_err with
 * a link partner model. assumes pulse outputs appear within three cycles.
 */
`timescale 1ns/100ps
module usb3_link_error_detect_bench;
    import ule_pkg::*;

    localparam logic [8:0] PEND = 9'h001;
    localparam logic [8:0] CRED = 9'h002;
    localparam logic [8:0] PM = 9'h004;
    localparam logic [8:0] LGO = 9'h008;
    localparam logic [8:0] LUP = 9'h010;
    localparam logic [8:0] U0 = 9'h020;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic is_dsp_i = 1'b1;
    logic [8:0] ev = '0;
    ule_sym_s sym;
    logic lbad_o, hp_good_o, lcmd_valid_o, recovery_o;
    logic [2:0] rx_hsn_o;
    ule_lcw_s lcmd_o;
    ule_cause_s cause_o;
    logic [CNT_W-1:0] link_err_cnt_o;
    logic [15:0] exp_cnt = '0;
    logic [3:0] seen;
    logic [7:0] s_cause;
    int bad_count = 0;
    int checks_done = 0;

    initial forever #5 clk_sys_i = ~clk_sys_i;

    ule_link_partner lp (.clk_sys_i(clk_sys_i), .sym_o(sym));

    ule_link_err dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sym_i(sym),
        .u0_entry_i(ev[5]), .is_dsp_i(is_dsp_i), .hot_reset_i(ev[6]),
        .warm_reset_i(ev[7]), .polling_idle_i(ev[8]),
        .pending_hp_expired_i(ev[0]), .credit_hp_expired_i(ev[1]),
        .pm_lc_expired_i(ev[2]), .lgo_sent_i(ev[3]), .lup_missing_i(ev[4]),
        .lbad_o(lbad_o), .hp_good_o(hp_good_o), .rx_hsn_o(rx_hsn_o),
        .lcmd_valid_o(lcmd_valid_o), .lcmd_o(lcmd_o),
        .recovery_o(recovery_o), .cause_o(cause_o), .link_err_cnt_o(link_err_cnt_o)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(input logic [8:0] v);
        // an edge passes before raising, so back-to-back pulses never meet in one time step
        @(posedge clk_sys_i);
        #1;
        ev = v;
        @(posedge clk_sys_i);
        #1;
        ev = '0;
    endtask

    // pulses are gathered over a short window so one-cycle outputs are not missed
    task automatic outcome(input logic [3:0] fl, input logic [3:0] mask, input logic [7:0] cause);
        seen = '0;
        s_cause = '0;
        repeat (3) begin
            seen |= {lbad_o, hp_good_o, lcmd_valid_o, recovery_o};
            s_cause |= cause_o;
            @(posedge clk_sys_i);
            #1;
        end
        cmp("pulses lbad good lcmd rec", {12'h0, fl & mask}, {12'h0, seen & mask});
        cmp("cause", {8'h0, cause}, {8'h0, s_cause});
        cmp("link_err_cnt", exp_cnt, link_err_cnt_o);
    endtask

    task automatic t_hdr();
        pulse(U0);
        for (int p = 0; p < 5; p++) begin
            lp.send_hp(3'(p), 0, (p == 4) ? 4'h0 : 4'(1 << p));
            outcome(4'h4, 4'hf, 8'h00);
            cmp("rx_hsn", 16'(p + 1), {13'h0, rx_hsn_o});
        end
        lp.send_hp(3'h5, 0, 4'h3);
        outcome(4'h0, 4'hf, 8'h00);
        for (int k = 1; k < 4; k++) begin
            lp.send_hp(3'h5, k, 4'h0);
            if (k == 3) exp_cnt++;
            outcome((k == 3) ? 4'h9 : 4'h8, 4'hf, (k == 3) ? 8'h04 : 8'h00);
        end
        pulse(U0);
        cmp("rx_hsn", 16'h0, {13'h0, rx_hsn_o});
        lp.send_hp(3'h3, 0, 4'h0);
        exp_cnt++;
        outcome(4'h1, 4'hf, 8'h08);
    endtask

    task automatic lc_case(input ule_lcw_s a, input ule_lcw_s b, input logic [3:0] bad, input logic v,
                           input ule_lcw_s w);
        lp.send_lc(a, b, bad);
        outcome({2'b00, v, 1'b0}, 4'hf, 8'h00);
        if (v) cmp("lcmd", w, lcmd_o);
    endtask

    task automatic t_lc();
        ule_lcw_s ok, alt, und, rsv, w;
        ok = lp.mk_lcw(LC_LRTY, 4'h0, 3'h0);
        alt = lp.mk_lcw(LC_LBAD, 4'h0, 3'h0);
        und = lp.mk_lcw(4'hf, 4'h0, 3'h0);
        rsv = lp.mk_lcw(LC_LRTY, 4'h2, 3'h0);
        lc_case(ok, ok, 4'h0, 1'b1, ok);
        lc_case(ok, ok ^ 16'h8000, 4'h8, 1'b1, ok);
        lc_case(ok ^ 16'h0800, alt, 4'h1, 1'b1, alt);
        lc_case(und, ok, 4'h0, 1'b1, ok);
        lc_case(ok, alt, 4'h0, 1'b0, ok);
        lc_case(und, und, 4'h0, 1'b0, ok);
        lc_case(rsv, rsv, 4'h4, 1'b0, ok);
        lc_case(ok, ok, 4'h3, 1'b0, ok);
        for (int m = 0; m < 2; m++) begin
            pulse(U0);
            for (int n = 0; n < 3; n++) begin
                w = lp.mk_lcw(m ? LC_LCRD : LC_LGOOD, 4'h0, 3'((n == 2) ? 3 : n));
                lp.send_lc(w, w, 4'h0);
                if (n == 2) exp_cnt++;
                outcome((n == 2) ? 4'h1 : 4'h2, (n == 2) ? 4'h1 : 4'hf, (n == 2) ? 8'h02 >> m : 8'h00);
            end
        end
    endtask

    task automatic t_timers();
        logic [8:0] src [4] = '{PEND, CRED, PM, LUP};
        ule_lcw_s w;
        for (int i = 0; i < 4; i++) begin
            pulse(U0);
            if (i == 2) pulse(LGO);
            pulse(src[i]);
            exp_cnt++;
            outcome(4'h1, 4'hf, 8'h80 >> i);
        end
        // both answers to a low-power request must stop the pm timer from recovering
        for (int j = 0; j < 2; j++) begin
            pulse(U0);
            pulse(LGO);
            w = lp.mk_lcw(j ? LC_LXU : LC_LAU, 4'h0, 3'h0);
            lp.send_lc(w, w, 4'h0);
            outcome(4'h2, 4'hf, 8'h00);
            pulse(PM);
            outcome(4'h0, 4'hf, 8'h00);
        end
        lp.send_lc(lp.mk_lcw(LC_LPMA, 4'h0, 3'h0), lp.mk_lcw(LC_LPMA, 4'h0, 3'h0), 4'h0);
        outcome(4'h2, 4'hf, 8'h00);
        is_dsp_i = 1'b0;
        pulse(PEND);
        outcome(4'h1, 4'hf, 8'h80);
        pulse(U0);
        pulse(LUP);
        outcome(4'h0, 4'hf, 8'h00);
        is_dsp_i = 1'b1;
    endtask

    task automatic t_clear();
        for (int c = 0; c < 3; c++) begin
            pulse(U0);
            pulse(PEND);
            exp_cnt++;
            outcome(4'h1, 4'hf, 8'h80);
            pulse(9'h040 << c);
            exp_cnt = '0;
            outcome(4'h0, 4'hf, 8'h00);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        cmp("link_err_cnt", 16'h0, link_err_cnt_o);
        t_hdr();
        t_lc();
        t_timers();
        t_clear();
        report_and_stop();
    end

    // cuts a hang short
    initial begin
        #500000;
        bad_count++;
        report_and_stop();
    end
endmodule // usb3_link_error_detect_bench
